// ### hw/sabs_acc_if.sv
// Sample hand-off between the sequencer and the accumulator.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
interface sabs_acc_if;
  logic clear;
  logic sample_valid;
  logic [11:0] sample;
  logic [1:0] rpt_sel;
  logic done;
  logic [15:0] sum;
  modport ctl (output clear, output sample_valid, output sample, output rpt_sel,
    input done, input sum);
  modport acc (input clear, input sample_valid, input sample, input rpt_sel,
    output done, output sum);
endinterface

// ### hw/sabs_accum.sv
// Sample accumulator: sums 1, 4, 8 or 16 samples and publishes the total.
// Assumes sample_valid is a one-cycle strobe on pclk.
`timescale 1ns/10ps
module sabs_accum
  import sabs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sample port
  sabs_acc_if.acc acc
);
  typedef struct packed {
    logic [15:0] part;
    logic [4:0] cnt;
    logic [15:0] sum;
    logic done;
  } sabs_acc_type;
  sabs_acc_type s_q, s_d;
  logic [15:0] total;

  // Result only moves on the last sample, so readers never see partial sums
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    total = s_q.part + {4'h0, acc.sample};
    if (acc.clear) begin
      s_d.part = '0;
      s_d.cnt = '0;
    end else if (acc.sample_valid) begin
      if (s_q.cnt + 5'h01 == sabs_rpt_target(acc.rpt_sel)) begin
        s_d.sum = total;
        s_d.done = 1'b1;
        s_d.part = '0;
        s_d.cnt = '0;
      end else begin
        s_d.part = total;
        s_d.cnt = s_q.cnt + 5'h01;
      end
    end
  end

  assign acc.done = s_q.done;
  assign acc.sum = s_q.sum;

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ### hw/sabs_divider.sv
// Enable-pulse divider: one output pulse per ratio+1 input pulses.
// Assumes tick_in is a one-cycle enable on pclk.
`timescale 1ns/10ps
module sabs_divider
  import sabs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic tick_in,
  input wire logic restart,
  input wire logic [4:0] ratio,
  // Divided enable
  output logic tick_out
);
  typedef struct packed {
    logic [4:0] cnt;
  } sabs_div_type;
  sabs_div_type s_q, s_d;

  // Restart aligns the first output period to the start of a phase
  always_comb begin
    s_d = s_q;
    if (restart) begin
      s_d.cnt = 5'h00;
    end else if (tick_in) begin
      s_d.cnt = (s_q.cnt == ratio) ? 5'h00 : s_q.cnt + 5'h01;
    end
  end

  assign tick_out = tick_in && !restart && (s_q.cnt == ratio);

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ### hw/sabs_pkg.sv
// Constants, types and helpers of the converter burst sequencer.
// Assumes a single 20 MHz clock; every slower rate is an enable pulse.
// Operation
// - Subsystem clock is the core clock when burst select is 0, burst oscillator when 1.
// - Conversion clock is the subsystem clock divided by a software divider field.
// - Sequencer is always in exactly one of idle, tracking or converting.
// - Pre-tracking starts converting at once after a start, with no timed tracking; the code does this outside burst only, burst still tracks.
// - Post and dual tracking track for the track-time value plus 2 subsystem cycles.
// - Conversion follows tracking immediately, with no idle gap.
// - A conversion takes 13 conversion-clock cycles plus 2 subsystem cycles.
// - Burst wakes the converter, takes 1, 4, 8 or 16 samples, then sleeps; the code sleeps only with converter-on 0.
// - Burst mode is active whenever burst select is 1, independent of core clock.
// - In burst with converter-on 0, power down after each burst.
// - In burst with converter-on 1, stay powered after each burst.
// - A powered-down converter waits the power-up time before tracking; else starts at once.
// - In burst, one start runs repeat-count conversions back to back.
// - Outside burst, each conversion needs its own start; accumulation advances per trigger.
// - Done flag is set only when accumulated conversions reach the repeat count.
// - Window compare runs only on the complete accumulated result.
// - Tracking mode codes: 10b pre, 01b post, 11b dual.
// - Post-tracking disconnects input after conversion; pre and dual track continuously; the code needs converter-on 1 in idle, dual only in power-up.
// - Start source: busy write 1, external pin rising edge, timer 1 or timer 2 overflow.
// - Busy reads 1 during conversion; its fall sets the done flag; the code sets it only when busy falls after the last accumulated conversion.
package sabs_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SABS_CFG_OFS = 8'h00;
  localparam logic [7:0] SABS_CTRL_OFS = 8'h04;
  localparam logic [7:0] SABS_RESULT_OFS = 8'h08;
  localparam logic [7:0] SABS_BDIV_OFS = 8'h0c;
  // Configuration fields
  localparam int SABS_DIV_LSB = 0;
  localparam int SABS_TRK_LSB = 8;
  localparam int SABS_PWR_LSB = 12;
  localparam int SABS_RPT_LSB = 16;
  // Control fields
  localparam int SABS_ON_BIT = 0;
  localparam int SABS_BURST_BIT = 1;
  localparam int SABS_TM_LSB = 2;
  localparam int SABS_SRC_LSB = 4;
  localparam int SABS_BUSY_BIT = 6;
  localparam int SABS_DONE_BIT = 7;
  localparam int SABS_STATE_LSB = 8;
  localparam int SABS_POWER_BIT = 12;
  // Reset values
  localparam logic [4:0] SABS_DIV_RST = 5'h1f;
  localparam logic [1:0] SABS_TRK_RST = 2'h0;
  localparam logic [3:0] SABS_PWR_RST = 4'h0;
  localparam logic [1:0] SABS_RPT_RST = 2'h0;
  localparam logic [4:0] SABS_BDIV_RST = 5'h00;
  // ----------------------------------------------------------------
  // Codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] SABS_TM_PRE = 2'h2;
  localparam logic [1:0] SABS_TM_POST = 2'h1;
  localparam logic [1:0] SABS_TM_DUAL = 2'h3;
  localparam logic [1:0] SABS_SRC_SW = 2'h0;
  localparam logic [1:0] SABS_SRC_EXT = 2'h1;
  localparam logic [1:0] SABS_SRC_TMR1 = 2'h2;
  localparam logic [1:0] SABS_SRC_TMR2 = 2'h3;
  localparam logic [7:0] SABS_TRACK_EXTRA = 8'h02;
  localparam logic [7:0] SABS_TRACK_STEP = 8'h04;
  localparam logic [7:0] SABS_PWRUP_STEP = 8'h08;
  localparam logic [3:0] SABS_SAR_LAST = 4'hc;
  typedef enum logic [3:0] {
    SABS_IDLE = 4'b0001,
    SABS_PWRUP = 4'b0010,
    SABS_TRACK = 4'b0100,
    SABS_CONV = 4'b1000
  } sabs_state_type;
  typedef enum logic [1:0] {
    SABS_PH_START = 2'h0,
    SABS_PH_SAR = 2'h1,
    SABS_PH_END = 2'h2
  } sabs_phase_type;

  // Repeat count code to number of samples
  function automatic logic [4:0] sabs_rpt_target(input logic [1:0] code);
    unique case (code)
      2'h0: sabs_rpt_target = 5'h01;
      2'h1: sabs_rpt_target = 5'h04;
      2'h2: sabs_rpt_target = 5'h08;
      default: sabs_rpt_target = 5'h10;
    endcase
  endfunction
endpackage

// ### hw/sabs_seq.sv
// Burst sequencer top: APB registers, start selection, subsystem and
// conversion clock enables, tracking / converting / idle sequencing.
// Assumes the analog core holds sar_result valid at the end of a conversion.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
module sabs_seq
  import sabs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Convert start sources
  input wire logic external_convert_start,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  // Analog core
  input wire logic [11:0] sar_result,
  output logic converter_subsystem_clock,
  output logic sar_clock_en,
  output logic converter_power,
  output logic sample_track,
  output logic [1:0] seq_state,
  // Window comparator feed
  output logic window_eval,
  output logic [15:0] window_value
);
  typedef struct packed {
    sabs_state_type st;
    sabs_phase_type ph;
    logic [7:0] cnt;
    logic [3:0] sar_n;
    logic [4:0] nconv;
    logic on;
    logic burst;
    logic [1:0] tm;
    logic [1:0] src;
    logic [4:0] div;
    logic [1:0] trk;
    logic [3:0] pwr;
    logic [1:0] rpt;
    logic [4:0] bdiv;
    logic busy;
    logic done;
    logic pend;
    logic ext_prev;
    logic sample_v;
    logic [11:0] sample;
    logic clear;
    logic [31:0] rdata;
    logic err;
    logic eval;
    logic [15:0] wval;
  } sabs_seq_type;
  sabs_seq_type s_q, s_d;

  sabs_acc_if acc_bus();
  logic burst_tick;
  logic converter_subsystem_clock_en;
  logic sar_tick;
  logic sar_restart;
  logic trigger;
  logic wr;
  logic setup;
  logic mapped;
  logic last;

  // ----------------------------------------------------------------
  // Clock enables
  // ----------------------------------------------------------------
  // Burst oscillator stand-in: free-running divided enable from pclk
  sabs_divider u_burst_osc (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(1'b1),
    .restart(1'b0),
    .ratio(s_q.bdiv),
    .tick_out(burst_tick)
  );

  // Subsystem clock follows burst select
  assign converter_subsystem_clock_en = s_q.burst ? burst_tick : 1'b1;

  // Conversion clock restarts at each conversion so 13 periods are exact
  assign sar_restart = !(s_q.st == SABS_CONV && s_q.ph == SABS_PH_SAR);
  sabs_divider u_sar_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(converter_subsystem_clock_en),
    .restart(sar_restart),
    .ratio(s_q.div),
    .tick_out(sar_tick)
  );

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  sabs_accum u_accum (
    .pclk(pclk),
    .presetn(presetn),
    .acc(acc_bus)
  );
  assign acc_bus.clear = s_q.clear;
  assign acc_bus.sample_valid = s_q.sample_v;
  assign acc_bus.sample = s_q.sample;
  assign acc_bus.rpt_sel = s_q.rpt;

  // ----------------------------------------------------------------
  // Bus decode and start selection
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign mapped = (paddr == SABS_CFG_OFS) || (paddr == SABS_CTRL_OFS) ||
    (paddr == SABS_RESULT_OFS) || (paddr == SABS_BDIV_OFS);

  // Pins are taken as synchronous, so a plain edge detect suffices
  always_comb begin
    unique case (s_q.src)
      SABS_SRC_SW: trigger = wr && (paddr == SABS_CTRL_OFS) && pwdata[SABS_BUSY_BIT];
      SABS_SRC_EXT: trigger = external_convert_start && !s_q.ext_prev;
      SABS_SRC_TMR1: trigger = timer1_ovf;
      default: trigger = timer2_ovf;
    endcase
  end

  assign last = (s_q.nconv + 5'h01) == sabs_rpt_target(s_q.rpt);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.sample_v = 1'b0;
    s_d.clear = 1'b0;
    s_d.eval = 1'b0;
    s_d.ext_prev = external_convert_start;

    // Register writes take effect on the access edge only
    if (wr) begin
      unique case (paddr)
        SABS_CFG_OFS: begin
          s_d.div = pwdata[SABS_DIV_LSB +: 5];
          s_d.trk = pwdata[SABS_TRK_LSB +: 2];
          s_d.pwr = pwdata[SABS_PWR_LSB +: 4];
          s_d.rpt = pwdata[SABS_RPT_LSB +: 2];
          s_d.nconv = '0;
          s_d.clear = 1'b1;
        end
        SABS_CTRL_OFS: begin
          s_d.on = pwdata[SABS_ON_BIT];
          s_d.burst = pwdata[SABS_BURST_BIT];
          s_d.tm = pwdata[SABS_TM_LSB +: 2];
          s_d.src = pwdata[SABS_SRC_LSB +: 2];
          if (pwdata[SABS_DONE_BIT]) begin
            s_d.done = 1'b0;
          end
        end
        SABS_BDIV_OFS: s_d.bdiv = pwdata[4:0];
        default: s_d.bdiv = s_q.bdiv;
      endcase
    end

    // Start is held until the subsystem clock takes it
    if (trigger && (s_q.on || s_q.burst)) begin
      s_d.pend = 1'b1;
      s_d.busy = 1'b1;
    end

    // Sequencer advances only on subsystem clock enables
    if (converter_subsystem_clock_en) begin
      unique case (s_q.st)
        SABS_IDLE: begin
          if (s_q.pend) begin
            s_d.pend = 1'b0;
            if (s_q.burst && !s_q.on) begin
              s_d.st = SABS_PWRUP;
              s_d.cnt = 8'(s_q.pwr) * SABS_PWRUP_STEP + SABS_PWRUP_STEP - 8'h01;
            end else if (!s_q.burst && s_q.tm == SABS_TM_PRE) begin
              s_d.st = SABS_CONV;
              s_d.ph = SABS_PH_START;
            end else begin
              s_d.st = SABS_TRACK;
              s_d.cnt = 8'(s_q.trk) * SABS_TRACK_STEP + SABS_TRACK_EXTRA - 8'h01;
            end
          end
        end
        SABS_PWRUP: begin
          if (s_q.cnt == 8'h00) begin
            s_d.st = SABS_TRACK;
            s_d.cnt = 8'(s_q.trk) * SABS_TRACK_STEP + SABS_TRACK_EXTRA - 8'h01;
          end else begin
            s_d.cnt = s_q.cnt - 8'h01;
          end
        end
        SABS_TRACK: begin
          if (s_q.cnt == 8'h00) begin
            s_d.st = SABS_CONV;
            s_d.ph = SABS_PH_START;
          end else begin
            s_d.cnt = s_q.cnt - 8'h01;
          end
        end
        SABS_CONV: begin
          unique case (s_q.ph)
            SABS_PH_START: begin
              s_d.ph = SABS_PH_SAR;
              s_d.sar_n = 4'h0;
            end
            SABS_PH_END: begin
              s_d.sample_v = 1'b1;
              s_d.sample = sar_result;
              s_d.nconv = last ? 5'h00 : s_q.nconv + 5'h01;
              if (s_q.burst && !last) begin
                s_d.st = SABS_TRACK;
                s_d.cnt = 8'(s_q.trk) * SABS_TRACK_STEP + SABS_TRACK_EXTRA - 8'h01;
              end else begin
                s_d.st = SABS_IDLE;
                s_d.busy = s_q.pend;
              end
            end
            default: s_d.ph = s_q.ph;
          endcase
        end
        default: s_d.st = SABS_IDLE;
      endcase
    end

    // SAR periods are counted on the divided enable
    if (s_q.st == SABS_CONV && s_q.ph == SABS_PH_SAR && sar_tick) begin
      if (s_q.sar_n == SABS_SAR_LAST) begin
        s_d.ph = SABS_PH_END;
      end else begin
        s_d.sar_n = s_q.sar_n + 4'h1;
      end
    end

    // Completion wins over a clear written in the same cycle
    if (acc_bus.done) begin
      s_d.done = 1'b1;
      s_d.eval = 1'b1;
      s_d.wval = acc_bus.sum;
    end

    // Read data is latched in setup so the access phase answers at once
    s_d.err = setup && !mapped;
    if (setup) begin
      s_d.rdata = '0;
      unique case (paddr)
        SABS_CFG_OFS: begin
          s_d.rdata[SABS_DIV_LSB +: 5] = s_q.div;
          s_d.rdata[SABS_TRK_LSB +: 2] = s_q.trk;
          s_d.rdata[SABS_PWR_LSB +: 4] = s_q.pwr;
          s_d.rdata[SABS_RPT_LSB +: 2] = s_q.rpt;
        end
        SABS_CTRL_OFS: begin
          s_d.rdata[SABS_ON_BIT] = s_q.on;
          s_d.rdata[SABS_BURST_BIT] = s_q.burst;
          s_d.rdata[SABS_TM_LSB +: 2] = s_q.tm;
          s_d.rdata[SABS_SRC_LSB +: 2] = s_q.src;
          s_d.rdata[SABS_BUSY_BIT] = s_q.busy;
          s_d.rdata[SABS_DONE_BIT] = s_q.done;
          s_d.rdata[SABS_STATE_LSB +: 4] = s_q.st;
          s_d.rdata[SABS_POWER_BIT] = converter_power;
        end
        SABS_RESULT_OFS: s_d.rdata[15:0] = acc_bus.sum;
        SABS_BDIV_OFS: s_d.rdata[4:0] = s_q.bdiv;
        default: s_d.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = s_q.err;
  assign converter_subsystem_clock = converter_subsystem_clock_en;
  assign sar_clock_en = sar_tick;
  // Burst power-down after a burst unless converter_on holds it up
  assign converter_power = s_q.on || (s_q.burst && s_q.st != SABS_IDLE);
  // Post-tracking leaves the input open between conversions
  assign sample_track = (s_q.st == SABS_TRACK) ||
    (s_q.st == SABS_PWRUP && s_q.tm == SABS_TM_DUAL) ||
    (s_q.st == SABS_IDLE && s_q.on && s_q.tm != SABS_TM_POST);
  // Power-up reports as idle: 0 idle, 1 tracking, 2 converting
  assign seq_state = (s_q.st == SABS_CONV) ? 2'h2 :
    (s_q.st == SABS_TRACK) ? 2'h1 : 2'h0;
  assign window_eval = s_q.eval;
  assign window_value = s_q.wval;

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= SABS_IDLE;
      s_q.ph <= SABS_PH_START;
      s_q.tm <= SABS_TM_POST;
      s_q.div <= SABS_DIV_RST;
      s_q.trk <= SABS_TRK_RST;
      s_q.pwr <= SABS_PWR_RST;
      s_q.rpt <= SABS_RPT_RST;
      s_q.bdiv <= SABS_BDIV_RST;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ### testbench/sabs_chk.sv
// Checker of the burst sequencer, bound to its top module ports.
// Assumes register writes take effect at the APB access edge, as in the design.
`timescale 1ns/10ps
module sabs_chk
  import sabs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB requests
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  // Sequencer outputs
  input wire logic converter_subsystem_clock,
  input wire logic sar_clock_en,
  input wire logic converter_power,
  input wire logic sample_track,
  input wire logic [1:0] seq_state,
  input wire logic window_eval
);
  // ----------------------------------------------------------------
  // Mirrors and counters
  // ----------------------------------------------------------------
  logic on_q, burst_q, was_conv_q, wr;
  logic [1:0] tm_q, trk_q, rpt_q;
  logic [4:0] div_q, sar_q, acc_q, want;
  logic [7:0] trk_n_q;
  logic [8:0] conv_n_q;
  assign wr = psel && penable && pwrite;
  // Shift amount is three bits wide so code 3 reaches sixteen
  assign want = (rpt_q == 2'h0) ? 5'h01 : 5'h01 << (rpt_q + 3'h1);
  // Track and conversion lengths count subsystem ticks so burst runs are measured the same way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tm_q, burst_q, on_q, trk_q, rpt_q, div_q} <= {4'h4, 4'h0, 5'h1f};
      {sar_q, acc_q, trk_n_q, conv_n_q, was_conv_q} <= '0;
    end else begin
      if (wr && paddr == SABS_CTRL_OFS)
        {tm_q, burst_q, on_q} <= pwdata[3:0];
      if (wr && paddr == SABS_CFG_OFS)
        {rpt_q, trk_q, div_q} <= {pwdata[17:16], pwdata[9:8], pwdata[4:0]};
      trk_n_q <= (seq_state == 2'h1) ? trk_n_q + 8'(converter_subsystem_clock) : 8'h00;
      conv_n_q <= (seq_state == 2'h2) ? conv_n_q + 9'(converter_subsystem_clock) : 9'h000;
      sar_q <= (seq_state == 2'h2) ? sar_q + 5'(sar_clock_en) : 5'h00;
      was_conv_q <= seq_state == 2'h2;
      if (window_eval || (wr && paddr == SABS_CFG_OFS))
        acc_q <= 5'h00;
      else if (was_conv_q && seq_state != 2'h2)
        acc_q <= acc_q + 5'h01;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_CLK_CORE: assert property (!burst_q |-> converter_subsystem_clock)
    else $error("subsystem clock not from core clock");
  AST_SAR_ONLY_CONV: assert property (sar_clock_en |-> seq_state == 2'h2)
    else $error("conversion clock outside converting");
  AST_STATE_LEGAL: assert property (seq_state != 2'h3)
    else $error("illegal sequencer state");
  AST_PRE_NO_TRACK: assert property (tm_q == SABS_TM_PRE && !burst_q |-> seq_state != 2'h1)
    else $error("timed tracking in pre mode");
  AST_TRACK_LEN: assert property ($fell(seq_state == 2'h1) |-> trk_n_q == 8'(4 * trk_q + 2))
    else $error("tracking length wrong");
  AST_TRACK_TO_CONV: assert property ($fell(seq_state == 2'h1) |-> seq_state == 2'h2)
    else $error("gap after tracking");
  AST_SAR_COUNT: assert property ($fell(seq_state == 2'h2) |-> sar_q == 5'h0d)
    else $error("conversion clock count wrong");
  AST_CONV_LEN: assert property ($fell(seq_state == 2'h2) |->
    conv_n_q == 9'(2 + 13 * (int'(div_q) + 1)))
    else $error("conversion length wrong");
  AST_DONE_COUNT: assert property (window_eval |-> acc_q == want)
    else $error("compare before full accumulation");
  AST_POWER_DOWN: assert property (window_eval && burst_q && !on_q |->
    ##[0:4] !converter_power)
    else $error("converter left powered after burst");
  AST_POWER_ON: assert property (burst_q && on_q |-> converter_power)
    else $error("converter powered down with on set");
  AST_POST_OPEN: assert property (tm_q == SABS_TM_POST && seq_state == 2'h0 |-> !sample_track)
    else $error("post mode tracks while idle");
  AST_IDLE_TRACK: assert property (tm_q[1] && seq_state == 2'h0 && converter_power |->
    sample_track)
    else $error("continuous tracking missing");
endmodule
bind sabs_seq sabs_chk chk_u (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .converter_subsystem_clock(converter_subsystem_clock),
  .sar_clock_en(sar_clock_en), .converter_power(converter_power),
  .sample_track(sample_track), .seq_state(seq_state), .window_eval(window_eval)
);

// ### testbench/sabs_src_model.sv
// Far-side model: convert-start pin, timer overflows and the analog result.
// Assumes the bench calls fire from one process, one start at a time.
`timescale 1ns/10ps
module sabs_src_model
(
  // Clock
  input wire logic pclk,
  // Level presented to the converter
  input wire logic [11:0] level,
  // Start sources and core result
  output logic external_convert_start,
  output logic timer1_ovf,
  output logic timer2_ovf,
  output logic [11:0] sar_result
);
  // Quiet sources from time zero
  initial begin
    external_convert_start = 1'b0;
    timer1_ovf = 1'b0;
    timer2_ovf = 1'b0;
  end
  // A steady level keeps accumulated sums exact
  assign sar_result = level;
  // Lead-in gap keeps starts four core clocks apart; pin pulse gives one rising edge
  task automatic fire(input logic [1:0] kind);
    repeat (4) @(posedge pclk);
    timer1_ovf <= kind == 2'h2;
    timer2_ovf <= kind == 2'h3;
    external_convert_start <= kind == 2'h1;
    @(posedge pclk);
    timer1_ovf <= 1'b0;
    timer2_ovf <= 1'b0;
    @(posedge pclk);
    external_convert_start <= 1'b0;
  endtask
endmodule

// ### testbench/sar_adc_burst_sequencer_test.sv
// Self-checking bench of the burst sequencer: table of runs, then reset cases.
// Assumes the source model drives start pins and result; APB has no wait states.
`timescale 1ns/10ps
module sar_adc_burst_sequencer_test
  import sabs_pkg::*;
;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [11:0] lvl;
  } sabs_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic ext_start, t1, t2, fe, sar_en, power, track, eval;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] level, result;
  logic [1:0] seq_state;
  logic [15:0] window_value;
  int n_mismatch = 0;
  int total_checks = 0;
  // Burst rows never use pre mode
  sabs_row_type rows [7] = '{'{32'h05, 32'h0, 12'h123}, '{32'h1d, 32'h10102, 12'hfff},
    '{32'h29, 32'h20000, 12'h800}, '{32'h35, 32'h1f, 12'h7ff},
    '{32'h06, 32'h31000, 12'hfff}, '{32'h2f, 32'h10000, 12'h800},
    '{32'h1e, 32'h20200, 12'h7ff}};
  sabs_seq dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_convert_start(ext_start), .timer1_ovf(t1), .timer2_ovf(t2),
    .sar_result(result), .converter_subsystem_clock(fe), .sar_clock_en(sar_en),
    .converter_power(power), .sample_track(track), .seq_state(seq_state),
    .window_eval(eval), .window_value(window_value));
  sabs_src_model src_u (.pclk(pclk), .level(level), .external_convert_start(ext_start),
    .timer1_ovf(t1), .timer2_ovf(t2), .sar_result(result));
  // 20 MHz core clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic stop_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; data and error are taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  // Bounded poll of one control bit
  task automatic poll(input int b, input logic v);
    int i;
    for (i = 0; i < 400; i++) begin
      apb(1'b0, SABS_CTRL_OFS, 32'h0);
      if (rd[b] === v)
        break;
    end
    if (i == 400) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  function automatic int count(input logic [1:0] code);
    return (code == 2'h0) ? 1 : 1 << (code + 1);
  endfunction
  // One run: burst takes one start, normal mode one start per sample
  task automatic run(input sabs_row_type r);
    int k, n;
    logic [15:0] sum;
    n = r.ctrl[SABS_BURST_BIT] ? 1 : count(r.cfg[17:16]);
    sum = 16'(count(r.cfg[17:16]) * r.lvl);
    level <= r.lvl;
    apb(1'b1, SABS_CFG_OFS, r.cfg);
    apb(1'b1, SABS_CTRL_OFS, r.ctrl);
    for (k = 0; k < n; k++) begin
      if (r.ctrl[5:4] == SABS_SRC_SW)
        apb(1'b1, SABS_CTRL_OFS, r.ctrl | 32'h40);
      else
        src_u.fire(r.ctrl[5:4]);
      poll(SABS_BUSY_BIT, 1'b0);
      apb(1'b0, SABS_CTRL_OFS, 32'h0);
      if (k < n - 1)
        check("early done", 32'h0, {31'h0, rd[SABS_DONE_BIT]});
    end
    poll(SABS_DONE_BIT, 1'b1);
    check("window value", {16'h0, sum}, {16'h0, window_value});
    apb(1'b0, SABS_RESULT_OFS, 32'h0);
    check("result", {16'h0, sum}, rd);
    check("power", {31'h0, r.ctrl[0]}, {31'h0, power});
    apb(1'b1, SABS_CTRL_OFS, r.ctrl | 32'h80);
    apb(1'b0, SABS_CTRL_OFS, 32'h0);
    check("done cleared", 32'h0, {31'h0, rd[SABS_DONE_BIT]});
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    level = 12'h000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, SABS_BDIV_OFS, 32'h1);
    foreach (rows[i])
      run(rows[i]);
    // Reset in mid-burst, then reset values; start decode uses the source already held
    apb(1'b1, SABS_CTRL_OFS, 32'h06);
    apb(1'b1, SABS_CTRL_OFS, 32'h46);
    repeat (20) @(posedge pclk);
    check("power in burst", 32'h1, {31'h0, power});
    presetn <= 1'b0;
    @(posedge pclk);
    check("state in reset", 32'h0, {30'h0, seq_state});
    check("power in reset", 32'h0, {31'h0, power});
    presetn <= 1'b1;
    apb(1'b0, SABS_CFG_OFS, 32'h0);
    check("cfg reset", 32'h1f, rd);
    apb(1'b0, SABS_BDIV_OFS, 32'h0);
    check("bdiv reset", 32'h0, rd);
    // Start with converter off outside burst is ignored
    apb(1'b1, SABS_CTRL_OFS, 32'h44);
    repeat (4) @(posedge pclk);
    apb(1'b0, SABS_CTRL_OFS, 32'h0);
    check("ctrl idle", 32'h4 | (32'(SABS_IDLE) << SABS_STATE_LSB), rd);
    // Unmapped address
    apb(1'b1, 8'h10, 32'hffff_ffff);
    check("unmapped write err", 32'h1, {31'h0, err});
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped data", 32'h0, rd);
    stop_test();
  end
endmodule
